// >>> verilog/tss_regs.svh
// Constants for the TCP socket state control block
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH
`define TSS_NUM_SOCK 8
`define TSS_SOCK_W 3
`define TSS_BUF_SIZE 16'h0800
`define TSS_PTR_RST 16'h0000
`define TSS_MODE_TCP 4'h1
`define TSS_CMD_NONE 8'h00
`define TSS_CMD_OPEN 8'h01
`define TSS_CMD_LISTEN 8'h02
`define TSS_CMD_CONNECT 8'h04
`define TSS_CMD_TEARDOWN_CMD_OR_FLAG 8'h08
`define TSS_CMD_CLOSE 8'h10
`define TSS_CMD_SEND 8'h20
`define TSS_CMD_RX_CONSUMED_CMD_OR_FLAG 8'h40
`define TSS_EV_LINK_UP 0
`define TSS_EV_TEARDOWN 1
`define TSS_EV_RX 2
`define TSS_EV_TIMEOUT 3
`define TSS_EV_TX_DONE 4
`define TSS_FLAGS_RST 8'h00
`define TSS_MASK_RST 8'hFF
`define TSS_CLK_NS 20
`define TSS_RETRY_UNIT_NS 100000
`define TSS_RETRY_UNIT_CYC (`TSS_RETRY_UNIT_NS / `TSS_CLK_NS)
`endif

// >>> verilog/tss_pkg.sv
// Types shared by the TCP socket state control block
package tss_pkg;
	typedef enum logic [3:0] {
		ST_SHUT, ST_PREPARED, ST_AWAITING_PEER, ST_HANDSHAKE_RX, ST_RESOLVING,
		ST_CONNECTING, ST_LINKED, ST_PEER_FINISHED, ST_CLOSING_ACTIVE, ST_CLOSING_LAST
	} tss_state_t;
	typedef enum logic [2:0] {
		WR_MODE, WR_PORT, WR_MASK, WR_FLAG_CLR, WR_RX_RD, WR_TX_WR, WR_CMD
	} tss_wr_kind_t;
	typedef enum logic [2:0] {
		SEG_NONE, SEG_SYN, SEG_SYNACK, SEG_ACK, SEG_FIN, SEG_DATA, SEG_ARP_REQ, SEG_ARP_REPLY
	} tss_seg_kind_t;
	typedef struct packed {
		logic valid;
		logic [2:0] sock;
		tss_wr_kind_t kind;
		logic [15:0] data;
	} tss_host_wr_t;
	typedef struct packed {
		logic [2:0] sock;
		tss_seg_kind_t kind;
		logic [15:0] len;
	} tss_seg_t;
	typedef struct packed {
		tss_state_t state;
		logic [7:0] command;
		logic [7:0] flags;
		logic [7:0] mask;
		logic [15:0] local_port;
		logic [15:0] rx_pending;
		logic [15:0] tx_free;
		logic [15:0] tx_read_ptr;
		logic resolution_to;
	} tss_rd_t;
endpackage

// >>> verilog/tss_socket_ctrl.sv
// TCP socket command and state engine for eight sockets
// Summary of operation
// - Open in TCP mode moves socket to prepared
// - Listen on prepared socket enters awaiting peer
// - Peer SYN: handshake state, answer SYN-ACK
// - Connection made: linked state, link-up flag
// - Event flag sets only when mask bit set
// - Flags clear by writing one; zero keeps
// - No flags left clears global socket bit
// - Receive flag is one merged level
// - Pending size nonzero whenever unread data
// - Oversized segment refused, connection paused
// - Send limited to buffer, cut at MSS
// - Read pointer advances by bytes sent
// - Peer FIN: teardown flag; linked goes to peer finished, active closing to shut
// - Disconnect command runs finish handshake
// - Retries exhausted: timeout flag, socket shut
// - Connect resolves, sends SYN, reports timeouts
// - Global flag and low interrupt when masked
// - Command register returns zero when processed
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"
module tss_socket_ctrl import tss_pkg::*; #(
	parameter int unsigned RETRY_UNIT_CYCLES = `TSS_RETRY_UNIT_CYC
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire tss_host_wr_t host_wr, // Host register write
	input wire logic [2:0] rd_sock, // Socket shown on rd_info
	output tss_rd_t rd_info, // Selected socket status
	output logic [7:0] global_socket_irq_flags, // Per-socket pending bits
	input wire logic [7:0] global_socket_irq_mask, // Per-socket enables
	output logic int_n, // Interrupt, active low
	input wire logic [15:0] retry_interval, // Retry period in units
	input wire logic [7:0] retry_limit, // Retries before timeout
	input wire logic [15:0] mss, // Maximum segment size
	input wire logic seg_in_valid, // Peer segment present
	input wire tss_seg_t seg_in, // Peer segment
	output logic seg_in_taken, // Segment accepted pulse
	output logic seg_in_paused, // Segment refused pulse
	output logic seg_out_valid, // Outgoing segment present
	output tss_seg_t seg_out, // Outgoing segment
	input wire logic seg_out_ready // Link takes segment
);
	localparam int NS = `TSS_NUM_SOCK;

	tss_state_t st_reg [NS];
	logic [7:0] cmd_reg [NS];
	logic [3:0] mode_reg [NS];
	logic [15:0] port_reg [NS];
	logic [7:0] mask_reg [NS];
	logic [7:0] flags_reg [NS];
	logic [15:0] rx_rd_reg [NS];
	logic [15:0] rx_commit_reg [NS];
	logic [15:0] rx_wr_reg [NS];
	logic [15:0] tx_wr_reg [NS];
	logic [15:0] tx_rd_reg [NS];
	logic need_v_reg [NS];
	tss_seg_kind_t need_kind_reg [NS];
	logic [15:0] need_len_reg [NS];
	tss_seg_kind_t pend_kind_reg [NS];
	logic [15:0] pend_len_reg [NS];
	logic wait_v_reg [NS];
	logic [15:0] wait_cnt_reg [NS];
	logic [7:0] retry_cnt_reg [NS];
	logic busy_reg [NS];
	logic resto_reg [NS];
	logic [15:0] unit_cnt_reg;
	logic tick;
	tss_seg_t head_reg, tail_reg;
	logic head_v_reg, tail_v_reg;
	logic [2:0] pick;
	logic pick_v, push, pop, take;
	tss_seg_t push_seg;
	logic [7:0] proc;
	logic [7:0] irq_now;

	// Free receive room counts only space released by receive-done
	function automatic logic [15:0] rx_free(input logic [15:0] wr, input logic [15:0] commit);
		rx_free = `TSS_BUF_SIZE - (wr - commit);
	endfunction

	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction

	function automatic logic retriable(input tss_seg_kind_t k);
		retriable = (k == SEG_SYN) || (k == SEG_SYNACK) || (k == SEG_FIN) ||
			(k == SEG_DATA) || (k == SEG_ARP_REQ);
	endfunction

	// Shared retry time base
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			unit_cnt_reg <= '0;
		end else if (unit_cnt_reg == 16'(RETRY_UNIT_CYCLES - 1)) begin
			unit_cnt_reg <= '0;
		end else begin
			unit_cnt_reg <= unit_cnt_reg + 16'h0001;
		end
	end
	assign tick = (unit_cnt_reg == 16'(RETRY_UNIT_CYCLES - 1));

	// Lowest socket with a segment to send wins the buffer slot
	always_comb begin
		pick = '0;
		pick_v = 1'b0;
		for (int i = NS - 1; i >= 0; i--) begin
			if (need_v_reg[i]) begin
				pick = 3'(i);
				pick_v = 1'b1;
			end
		end
	end
	assign push = pick_v && !tail_v_reg;
	assign push_seg = '{sock: pick, kind: need_kind_reg[pick], len: need_len_reg[pick]};
	assign pop = head_v_reg && seg_out_ready;

	// Peer segment acceptance; a busy send slot or no room pauses the peer
	always_comb begin
		take = seg_in_valid;
		if ((seg_in.kind == SEG_SYN || seg_in.kind == SEG_SYNACK || seg_in.kind == SEG_FIN ||
			seg_in.kind == SEG_DATA) && need_v_reg[seg_in.sock]) begin
			take = 1'b0;
		end
		if (seg_in.kind == SEG_DATA &&
			seg_in.len > rx_free(rx_wr_reg[seg_in.sock], rx_commit_reg[seg_in.sock])) begin
			take = 1'b0;
		end
	end

	// Commands wait while the socket still owns an unsent segment
	always_comb begin
		for (int i = 0; i < NS; i++) begin
			proc[i] = (cmd_reg[i] != `TSS_CMD_NONE) && !need_v_reg[i] &&
				!(take && seg_in.sock == 3'(i));
		end
	end

	// Socket engine: commands, peer segments, retries, event flags
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NS; i++) begin
				st_reg[i] <= ST_SHUT;
				cmd_reg[i] <= `TSS_CMD_NONE;
				mode_reg[i] <= '0;
				port_reg[i] <= '0;
				mask_reg[i] <= `TSS_MASK_RST;
				flags_reg[i] <= `TSS_FLAGS_RST;
				rx_rd_reg[i] <= `TSS_PTR_RST;
				rx_commit_reg[i] <= `TSS_PTR_RST;
				rx_wr_reg[i] <= `TSS_PTR_RST;
				tx_wr_reg[i] <= `TSS_PTR_RST;
				tx_rd_reg[i] <= `TSS_PTR_RST;
				need_v_reg[i] <= 1'b0;
				need_kind_reg[i] <= SEG_NONE;
				need_len_reg[i] <= '0;
				pend_kind_reg[i] <= SEG_NONE;
				pend_len_reg[i] <= '0;
				wait_v_reg[i] <= 1'b0;
				wait_cnt_reg[i] <= '0;
				retry_cnt_reg[i] <= '0;
				busy_reg[i] <= 1'b0;
				resto_reg[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < NS; i++) begin
				logic [7:0] set_v;
				logic [7:0] clr_v;
				logic hw, pr;
				set_v = '0;
				clr_v = '0;
				hw = host_wr.valid && host_wr.sock == 3'(i);
				pr = take && seg_in.sock == 3'(i);
				// Segment handed to the buffer; arm the retry timer unless it is an ACK
				if (push && pick == 3'(i)) begin
					need_v_reg[i] <= 1'b0;
					if (retriable(need_kind_reg[i])) begin
						pend_kind_reg[i] <= need_kind_reg[i];
						pend_len_reg[i] <= need_len_reg[i];
						wait_v_reg[i] <= 1'b1;
						wait_cnt_reg[i] <= '0;
					end
				end
				// Command processing; illegal ones only clear the register
				if (proc[i]) begin
					cmd_reg[i] <= `TSS_CMD_NONE;
					unique case (cmd_reg[i])
					`TSS_CMD_OPEN: if (st_reg[i] == ST_SHUT && mode_reg[i] == `TSS_MODE_TCP) begin
						st_reg[i] <= ST_PREPARED;
						rx_wr_reg[i] <= `TSS_PTR_RST;
						rx_commit_reg[i] <= `TSS_PTR_RST;
						rx_rd_reg[i] <= `TSS_PTR_RST;
						tx_rd_reg[i] <= `TSS_PTR_RST;
						tx_wr_reg[i] <= `TSS_PTR_RST;
						resto_reg[i] <= 1'b0;
					end
					`TSS_CMD_LISTEN: if (st_reg[i] == ST_PREPARED) begin
						st_reg[i] <= ST_AWAITING_PEER;
					end
					`TSS_CMD_CONNECT: if (st_reg[i] == ST_PREPARED) begin
						st_reg[i] <= ST_RESOLVING;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_ARP_REQ;
						need_len_reg[i] <= '0;
						retry_cnt_reg[i] <= '0;
					end
					`TSS_CMD_SEND: if (st_reg[i] == ST_LINKED && !busy_reg[i] &&
						tx_wr_reg[i] != tx_rd_reg[i]) begin
						busy_reg[i] <= 1'b1;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_DATA;
						need_len_reg[i] <= min16(min16(tx_wr_reg[i] - tx_rd_reg[i], mss),
							`TSS_BUF_SIZE);
						retry_cnt_reg[i] <= '0;
					end
					`TSS_CMD_RX_CONSUMED_CMD_OR_FLAG: begin
						rx_commit_reg[i] <= rx_rd_reg[i];
					end
					`TSS_CMD_TEARDOWN_CMD_OR_FLAG: if (st_reg[i] == ST_LINKED || st_reg[i] == ST_PEER_FINISHED) begin
						st_reg[i] <= (st_reg[i] == ST_LINKED) ? ST_CLOSING_ACTIVE : ST_CLOSING_LAST;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_FIN;
						need_len_reg[i] <= '0;
						retry_cnt_reg[i] <= '0;
						busy_reg[i] <= 1'b0;
					end
					`TSS_CMD_CLOSE: begin
						st_reg[i] <= ST_SHUT;
						wait_v_reg[i] <= 1'b0;
						busy_reg[i] <= 1'b0;
					end
					default: ;
					endcase
				end
				// Peer segments steer the connection
				if (pr) begin
					unique case (seg_in.kind)
					SEG_ARP_REPLY: if (st_reg[i] == ST_RESOLVING) begin
						st_reg[i] <= ST_CONNECTING;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_SYN;
						need_len_reg[i] <= '0;
						wait_v_reg[i] <= 1'b0;
						retry_cnt_reg[i] <= '0;
					end
					SEG_SYN: if (st_reg[i] == ST_AWAITING_PEER) begin
						st_reg[i] <= ST_HANDSHAKE_RX;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_SYNACK;
						need_len_reg[i] <= '0;
						retry_cnt_reg[i] <= '0;
					end
					SEG_SYNACK: if (st_reg[i] == ST_CONNECTING) begin
						st_reg[i] <= ST_LINKED;
						set_v[`TSS_EV_LINK_UP] = 1'b1;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_ACK;
						need_len_reg[i] <= '0;
						wait_v_reg[i] <= 1'b0;
					end
					SEG_ACK: begin
						if (st_reg[i] == ST_HANDSHAKE_RX) begin
							st_reg[i] <= ST_LINKED;
							set_v[`TSS_EV_LINK_UP] = 1'b1;
							wait_v_reg[i] <= 1'b0;
						end else if (st_reg[i] == ST_LINKED && busy_reg[i] && wait_v_reg[i]) begin
							tx_rd_reg[i] <= tx_rd_reg[i] + pend_len_reg[i];
							busy_reg[i] <= 1'b0;
							wait_v_reg[i] <= 1'b0;
							set_v[`TSS_EV_TX_DONE] = 1'b1;
						end else if (st_reg[i] == ST_CLOSING_ACTIVE) begin
							wait_v_reg[i] <= 1'b0;
						end else if (st_reg[i] == ST_CLOSING_LAST) begin
							st_reg[i] <= ST_SHUT;
							wait_v_reg[i] <= 1'b0;
							set_v[`TSS_EV_TEARDOWN] = 1'b1;
						end
					end
					SEG_DATA: if (st_reg[i] == ST_LINKED || st_reg[i] == ST_CLOSING_ACTIVE) begin
						rx_wr_reg[i] <= rx_wr_reg[i] + seg_in.len;
						set_v[`TSS_EV_RX] = 1'b1;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_ACK;
						need_len_reg[i] <= '0;
					end
					SEG_FIN: if (st_reg[i] == ST_LINKED || st_reg[i] == ST_CLOSING_ACTIVE) begin
						st_reg[i] <= (st_reg[i] == ST_LINKED) ? ST_PEER_FINISHED : ST_SHUT;
						set_v[`TSS_EV_TEARDOWN] = 1'b1;
						need_v_reg[i] <= 1'b1;
						need_kind_reg[i] <= SEG_ACK;
						need_len_reg[i] <= '0;
						wait_v_reg[i] <= 1'b0;
					end
					default: ;
					endcase
				end
				// Retry timer; exhaustion shuts the socket
				if (wait_v_reg[i] && tick && !pr) begin
					if (wait_cnt_reg[i] + 16'h0001 >= retry_interval) begin
						wait_cnt_reg[i] <= '0;
						if (retry_cnt_reg[i] >= retry_limit) begin
							st_reg[i] <= ST_SHUT;
							set_v[`TSS_EV_TIMEOUT] = 1'b1;
							resto_reg[i] <= (st_reg[i] == ST_RESOLVING);
							wait_v_reg[i] <= 1'b0;
							busy_reg[i] <= 1'b0;
							need_v_reg[i] <= 1'b0;
						end else if (!need_v_reg[i]) begin
							retry_cnt_reg[i] <= retry_cnt_reg[i] + 8'h01;
							need_v_reg[i] <= 1'b1;
							need_kind_reg[i] <= pend_kind_reg[i];
							need_len_reg[i] <= pend_len_reg[i];
						end
					end else begin
						wait_cnt_reg[i] <= wait_cnt_reg[i] + 16'h0001;
					end
				end
				// Host register writes; a fresh command overrides the clear
				if (hw) begin
					unique case (host_wr.kind)
					WR_MODE: mode_reg[i] <= host_wr.data[3:0];
					WR_PORT: port_reg[i] <= host_wr.data;
					WR_MASK: mask_reg[i] <= host_wr.data[7:0];
					WR_FLAG_CLR: clr_v = host_wr.data[7:0];
					WR_RX_RD: rx_rd_reg[i] <= host_wr.data;
					WR_TX_WR: tx_wr_reg[i] <= host_wr.data;
					WR_CMD: cmd_reg[i] <= host_wr.data[7:0];
					default: ;
					endcase
				end
				// Set wins over write-one clear, gated by the mask
				flags_reg[i] <= (flags_reg[i] & ~clr_v) | (set_v & mask_reg[i]);
			end
		end
	end

	// Two-entry output buffer; the link may stall without losing a segment
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			head_reg <= '0;
			tail_reg <= '0;
			head_v_reg <= 1'b0;
			tail_v_reg <= 1'b0;
		end else if (pop) begin
			if (tail_v_reg) begin
				head_reg <= tail_reg;
				tail_v_reg <= 1'b0;
			end else begin
				head_v_reg <= push;
				head_reg <= push_seg;
			end
		end else if (push) begin
			if (!head_v_reg) begin
				head_reg <= push_seg;
				head_v_reg <= 1'b1;
			end else begin
				tail_reg <= push_seg;
				tail_v_reg <= 1'b1;
			end
		end
	end
	assign seg_out = head_reg;
	assign seg_out_valid = head_v_reg;

	// Global socket bits follow flags and masks with no host action
	always_comb begin
		for (int i = 0; i < NS; i++) begin
			irq_now[i] = |(flags_reg[i] & mask_reg[i]);
		end
	end

	// Interrupt and status outputs, all registered
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			global_socket_irq_flags <= '0;
			int_n <= 1'b1;
			seg_in_taken <= 1'b0;
			seg_in_paused <= 1'b0;
			rd_info <= '0;
		end else begin
			global_socket_irq_flags <= irq_now;
			int_n <= ~|(irq_now & global_socket_irq_mask);
			seg_in_taken <= take;
			seg_in_paused <= seg_in_valid && !take;
			rd_info.state <= st_reg[rd_sock];
			rd_info.command <= cmd_reg[rd_sock];
			rd_info.flags <= flags_reg[rd_sock];
			rd_info.mask <= mask_reg[rd_sock];
			rd_info.local_port <= port_reg[rd_sock];
			rd_info.rx_pending <= rx_wr_reg[rd_sock] - rx_rd_reg[rd_sock];
			rd_info.tx_free <= `TSS_BUF_SIZE - (tx_wr_reg[rd_sock] - tx_rd_reg[rd_sock]);
			rd_info.tx_read_ptr <= tx_rd_reg[rd_sock];
			rd_info.resolution_to <= resto_reg[rd_sock];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_open_prepared: assert property (
		proc[0] && cmd_reg[0] == `TSS_CMD_OPEN && st_reg[0] == ST_SHUT &&
		mode_reg[0] == `TSS_MODE_TCP |=> st_reg[0] == ST_PREPARED)
		else $error("open did not prepare socket");
	a_listen_state: assert property (
		proc[0] && cmd_reg[0] == `TSS_CMD_LISTEN && st_reg[0] == ST_PREPARED &&
		!(wait_v_reg[0] && tick) |=> st_reg[0] == ST_AWAITING_PEER)
		else $error("listen did not reach awaiting state");
	a_syn_answer: assert property (
		take && seg_in.sock == 3'h0 && seg_in.kind == SEG_SYN && st_reg[0] == ST_AWAITING_PEER
		|=> st_reg[0] == ST_HANDSHAKE_RX && need_kind_reg[0] == SEG_SYNACK)
		else $error("SYN not answered");
	a_link_flag: assert property (
		st_reg[0] != ST_LINKED ##1 st_reg[0] == ST_LINKED && mask_reg[0][`TSS_EV_LINK_UP]
		&& $stable(mask_reg[0]) |-> flags_reg[0][`TSS_EV_LINK_UP])
		else $error("link-up flag missing");
	a_flag_masked: assert property (
		$rose(flags_reg[0][`TSS_EV_RX]) |-> $past(mask_reg[0][`TSS_EV_RX]))
		else $error("flag set while masked");
	a_flag_hold: assert property (
		flags_reg[0][`TSS_EV_TEARDOWN] && !(host_wr.valid && host_wr.sock == 3'h0 &&
		host_wr.kind == WR_FLAG_CLR && host_wr.data[`TSS_EV_TEARDOWN])
		|=> flags_reg[0][`TSS_EV_TEARDOWN])
		else $error("flag lost without clear");
	a_girq_auto: assert property (
		(flags_reg[2] & mask_reg[2]) == 8'h00 |=> !global_socket_irq_flags[2])
		else $error("global bit not cleared");
	a_rx_pause: assert property (
		seg_in_valid && seg_in.kind == SEG_DATA && seg_in.sock == 3'h0 &&
		seg_in.len > rx_free(rx_wr_reg[0], rx_commit_reg[0])
		|=> $stable(rx_wr_reg[0]) ##0 seg_in_paused)
		else $error("oversized segment accepted");
	a_seg_mss: assert property (
		push && push_seg.kind == SEG_DATA && $stable(mss) |-> push_seg.len <= mss)
		else $error("data segment above MSS");
	a_timeout_shut: assert property (
		$rose(flags_reg[2][`TSS_EV_TIMEOUT]) |-> st_reg[2] == ST_SHUT)
		else $error("timeout without shut state");
	a_int_low: assert property (
		int_n == 1'b0 |-> $past(|(irq_now & global_socket_irq_mask)))
		else $error("interrupt without masked source");
	a_cmd_zero: assert property (
		proc[0] && !(host_wr.valid && host_wr.sock == 3'h0 && host_wr.kind == WR_CMD)
		|=> cmd_reg[0] == `TSS_CMD_NONE)
		else $error("command register not cleared");

	c_server_link: cover property (st_reg[0] == ST_HANDSHAKE_RX ##[1:50] st_reg[0] == ST_LINKED);
	c_client_link: cover property (st_reg[1] == ST_CONNECTING ##[1:50] st_reg[1] == ST_LINKED);
	c_buffer_full: cover property (tail_v_reg && !seg_out_ready);
	c_rx_paused: cover property (seg_in_paused);
endmodule
`default_nettype wire

// >>> tb/tss_peer_model.sv
// Behavioural remote TCP peer facing the socket engine
`timescale 1ns/1ps
`default_nettype none
module tss_peer_model import tss_pkg::*; (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic req_valid, // Bench asks for a segment
	input wire tss_seg_t req, // Segment asked for
	input wire logic mute, // Peer stops answering
	input wire logic stall, // Peer refuses device segments
	output logic seg_in_valid, // Segment offered
	output tss_seg_t seg_in, // Offered segment
	input wire logic seg_in_taken, // Accepted pulse
	input wire logic seg_in_paused, // Refused pulse
	input wire logic seg_out_valid, // Device segment present
	input wire tss_seg_t seg_out, // Device segment
	output logic seg_out_ready // Peer takes segment
);
	tss_seg_t q[$];
	tss_seg_t ans;
	logic waiting;
	logic [7:0] fin_sent;
	assign seg_out_ready = !stall;
	// Answer each device segment other than an ACK as a real stack would; ACKs get no reply
	always_comb begin
		ans = seg_out;
		case (seg_out.kind)
			SEG_SYN: ans.kind = SEG_SYNACK;
			SEG_SYNACK, SEG_DATA: ans.kind = SEG_ACK;
			SEG_ARP_REQ: ans.kind = SEG_ARP_REPLY;
			SEG_FIN: ans.kind = fin_sent[seg_out.sock] ? SEG_ACK : SEG_FIN;
			default: ans.kind = SEG_NONE;
		endcase
	end
	// One offer, then one cycle to learn its fate; idle lines keep toggling
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q.delete();
			seg_in_valid <= 1'b0;
			seg_in <= '0;
			waiting <= 1'b0;
			fin_sent <= 8'h00;
		end else begin
			if (req_valid) begin
				q.push_back(req);
				if (req.kind == SEG_FIN) fin_sent[req.sock] <= 1'b1;
			end
			if (seg_out_valid && seg_out_ready && !mute && ans.kind != SEG_NONE) q.push_back(ans);
			if (seg_in_valid) begin
				seg_in_valid <= 1'b0;
				seg_in <= tss_seg_t'(~seg_in);
				waiting <= 1'b1;
			end else if (waiting) begin
				waiting <= 1'b0;
				seg_in <= tss_seg_t'(~seg_in);
				if (seg_in_taken && !seg_in_paused) void'(q.pop_front());
			end else if (q.size() > 0) begin
				seg_in_valid <= 1'b1;
				seg_in <= q[0];
			end else begin
				seg_in <= tss_seg_t'(~seg_in);
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/tcp_socket_state_control_tb.sv
// Self-checking bench for the TCP socket state control block
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"
module tcp_socket_state_control_tb import tss_pkg::*;;
	logic clk, nrst, int_n, req_valid, mute, stall;
	logic seg_in_valid, seg_in_taken, seg_in_paused, seg_out_valid, seg_out_ready;
	tss_host_wr_t host_wr;
	logic [2:0] rd_sock;
	tss_rd_t rd_info;
	logic [7:0] gflags, gmask, retry_limit;
	logic [15:0] retry_interval, mss;
	tss_seg_t seg_in, seg_out, req;
	tss_seg_t last_out = '0;
	int err_count, n_checks;
	tss_socket_ctrl #(.RETRY_UNIT_CYCLES(4)) tss_socket_ctrl_inst (.clk(clk), .nrst(nrst),
		.host_wr(host_wr), .rd_sock(rd_sock), .rd_info(rd_info),
		.global_socket_irq_flags(gflags), .global_socket_irq_mask(gmask), .int_n(int_n),
		.retry_interval(retry_interval), .retry_limit(retry_limit), .mss(mss),
		.seg_in_valid(seg_in_valid), .seg_in(seg_in), .seg_in_taken(seg_in_taken),
		.seg_in_paused(seg_in_paused), .seg_out_valid(seg_out_valid), .seg_out(seg_out),
		.seg_out_ready(seg_out_ready));
	tss_peer_model tss_peer_model_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req(req), .mute(mute), .stall(stall), .seg_in_valid(seg_in_valid), .seg_in(seg_in),
		.seg_in_taken(seg_in_taken), .seg_in_paused(seg_in_paused),
		.seg_out_valid(seg_out_valid), .seg_out(seg_out), .seg_out_ready(seg_out_ready));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Remember the last data segment the peer accepted
	always @(posedge clk) if (seg_out_valid && seg_out_ready && seg_out.kind == SEG_DATA) last_out <= seg_out;
	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] s, input tss_wr_kind_t k, input logic [15:0] d);
		@(posedge clk) host_wr <= '{1'b1, s, k, d};
		@(posedge clk) host_wr.valid <= 1'b0;
	endtask
	task automatic send(input logic [2:0] s, input tss_seg_kind_t k, input logic [15:0] l);
		@(posedge clk) req <= '{s, k, l};
		req_valid <= 1'b1;
		@(posedge clk) req_valid <= 1'b0;
	endtask
	// Status read: rd_info lags the select by a register
	task automatic rd(input logic [2:0] s);
		@(posedge clk) rd_sock <= s;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Poll a state (is_flag 0) or an event bit (is_flag 1) with a bound
	task automatic wait_for(input logic [2:0] s, input logic is_flag, input logic [3:0] v);
		int i;
		for (i = 0; i < 100; i++) begin
			rd(s);
			if (is_flag ? rd_info.flags[v[2:0]] === 1'b1 : rd_info.state === v) break;
		end
		n_checks++;
		if (i == 100) begin
			err_count++;
			$display("wrong value wait expected %h seen %h", v, rd_info.state);
			wrap_up();
		end
	endtask
	task automatic cmd(input logic [2:0] s, input logic [7:0] c);
		int i;
		wr(s, WR_CMD, {8'h00, c});
		for (i = 0; i < 50; i++) begin
			rd(s);
			if (rd_info.command === 8'h00) break;
		end
		chk("command", 16'h0000, rd_info.command);
		if (i == 50) wrap_up();
	endtask
	task automatic t_server();
		wr(0, WR_MODE, `TSS_MODE_TCP);
		wr(0, WR_PORT, 16'h1F90);
		cmd(0, `TSS_CMD_OPEN);
		wait_for(0, 0, ST_PREPARED);
		chk("port", 16'h1F90, rd_info.local_port);
		cmd(0, `TSS_CMD_LISTEN);
		wait_for(0, 0, ST_AWAITING_PEER);
		@(posedge clk) stall <= 1'b1;
		send(0, SEG_SYN, 16'h0000);
		wait_for(0, 0, ST_HANDSHAKE_RX);
		chk("out kind", SEG_SYNACK, seg_out.kind);
		@(posedge clk) stall <= 1'b0;
		wait_for(0, 0, ST_LINKED);
		chk("flags", 16'h0001, rd_info.flags);
		chk("gflag", 16'h0001, gflags[0]);
		chk("int_n", 16'h0000, int_n);
		cmd(0, `TSS_CMD_LISTEN);
		chk("state", ST_LINKED, rd_info.state);
		wr(0, WR_FLAG_CLR, 16'h00FE);
		@(posedge clk) gmask <= 8'hFE;
		rd(0);
		chk("flags", 16'h0001, rd_info.flags);
		chk("int_n", 16'h0001, int_n);
		@(posedge clk) gmask <= 8'hFF;
		wr(0, WR_FLAG_CLR, 16'h0001);
		rd(0);
		chk("flags", 16'h0000, rd_info.flags);
		chk("gflag", 16'h0000, gflags[0]);
	endtask
	task automatic t_receive();
		@(posedge clk) stall <= 1'b1;
		send(0, SEG_DATA, 16'h0100);
		send(0, SEG_DATA, 16'h0100);
		repeat (4) @(posedge clk);
		rd(0);
		chk("pending", 16'h0200, rd_info.rx_pending);
		chk("flags", 16'h0004, rd_info.flags);
		chk("out valid", 16'h0001, seg_out_valid);
		@(posedge clk) stall <= 1'b0;
		wr(0, WR_FLAG_CLR, 16'h0004);
		rd(0);
		chk("flags", 16'h0000, rd_info.flags);
		send(0, SEG_DATA, 16'h0700);
		repeat (8) @(posedge clk);
		rd(0);
		chk("pending", 16'h0200, rd_info.rx_pending);
		wr(0, WR_RX_RD, 16'h0200);
		cmd(0, `TSS_CMD_RX_CONSUMED_CMD_OR_FLAG);
		repeat (8) @(posedge clk);
		rd(0);
		chk("pending", 16'h0700, rd_info.rx_pending);
		wr(0, WR_FLAG_CLR, 16'h00FF);
		wr(0, WR_MASK, 16'h00FB);
		send(0, SEG_DATA, 16'h0010);
		repeat (6) @(posedge clk);
		rd(0);
		chk("flags", 16'h0000, rd_info.flags);
		chk("pending", 16'h0710, rd_info.rx_pending);
		wr(0, WR_MASK, 16'h00FF);
	endtask
	task automatic t_send();
		wr(0, WR_TX_WR, 16'h0180);
		rd(0);
		chk("free", 16'h0680, rd_info.tx_free);
		cmd(0, `TSS_CMD_SEND);
		wait_for(0, 1, `TSS_EV_TX_DONE);
		chk("tx len", 16'h0100, last_out.len);
		chk("tx rd", 16'h0100, rd_info.tx_read_ptr);
		wr(0, WR_FLAG_CLR, 16'h0010);
		cmd(0, `TSS_CMD_SEND);
		wait_for(0, 1, `TSS_EV_TX_DONE);
		chk("tx len", 16'h0080, last_out.len);
		chk("tx rd", 16'h0180, rd_info.tx_read_ptr);
		chk("tx offset", 16'h0180, rd_info.tx_read_ptr & (`TSS_BUF_SIZE - 16'h0001));
		chk("free", 16'h0800, rd_info.tx_free);
	endtask
	task automatic t_close();
		send(0, SEG_FIN, 16'h0000);
		wait_for(0, 0, ST_PEER_FINISHED);
		chk("teardown", 16'h0001, rd_info.flags[`TSS_EV_TEARDOWN]);
		cmd(0, `TSS_CMD_TEARDOWN_CMD_OR_FLAG);
		wait_for(0, 0, ST_SHUT);
		wr(0, WR_FLAG_CLR, 16'h00FF);
		cmd(0, `TSS_CMD_CLOSE);
		chk("flags", 16'h0000, rd_info.flags);
		chk("gflag", 16'h0000, gflags[0]);
	endtask
	task automatic t_client();
		wr(1, WR_MODE, `TSS_MODE_TCP);
		cmd(1, `TSS_CMD_OPEN);
		cmd(1, `TSS_CMD_CONNECT);
		wait_for(1, 0, ST_LINKED);
		cmd(1, `TSS_CMD_TEARDOWN_CMD_OR_FLAG);
		wait_for(1, 0, ST_SHUT);
		chk("teardown", 16'h0001, rd_info.flags[`TSS_EV_TEARDOWN]);
		@(posedge clk) mute <= 1'b1;
		wr(2, WR_MODE, `TSS_MODE_TCP);
		cmd(2, `TSS_CMD_OPEN);
		cmd(2, `TSS_CMD_CONNECT);
		wait_for(2, 0, ST_SHUT);
		chk("timeout", 16'h0001, rd_info.flags[`TSS_EV_TIMEOUT]);
		chk("resolve", 16'h0001, rd_info.resolution_to);
	endtask
	initial begin
		nrst = 1'b0;
		host_wr = '0;
		rd_sock = 3'h0;
		gmask = 8'hFF;
		// Retry period above one peer round trip, so no spurious resends
		retry_interval = 16'h0004;
		retry_limit = 8'h02;
		mss = 16'h0100;
		req_valid = 1'b0;
		req = '0;
		mute = 1'b0;
		stall = 1'b0;
		err_count = 0;
		n_checks = 0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(0);
		chk("mask", 16'h00FF, rd_info.mask);
		chk("int_n", 16'h0001, int_n);
		t_server();
		t_receive();
		t_send();
		t_close();
		t_client();
		wrap_up();
	end
endmodule
`default_nettype wire
